// >>> dram_host_ctrl.sv
// Host controller driving a page-mode DRAM module through its strobes
// Operation
// - Row strobe stays high at least the row precharge time between cycles.
// - Early write: write line low at least write setup before column fall.
// - Strobes stay low the row and column hold-after-write times.
// - Page cycle: column strobe high column precharge time, row strobe low.
// - Burst limited to page maximum; row rises with or after column.
// - All 1024 rows refreshed within 16 ms, or 128 ms low power.
// - Distributed refresh: one row each 15.6 us, or 124.8 us.
// - Row-only refresh: row strobe falls with row address, column stays high.
// - Write line high around row fall in column before row refresh.
// - Hidden refresh: column held low while row strobe cycles; not used, CBR refresh starts only from idle.
// - At least 8 column before row cycles precede the counter test.
// - Counter test sequence of zeros, ones, then complement data; the controller issues single test cycles, the user builds the sequence.
// - After power-up wait 200 us, then eight row strobe cycles.
// - Ten address lines carry row, then column, at strobe falls.
// - Read: write line high at least read setup before column fall.
`timescale 1ns/100ps
`include "dram_host_consts.svh"
module dram_host_ctrl
   import dram_host_pkg::*;
#(
   parameter bit LOW_POWER       = 1'b0,
   parameter int INIT_CYCLES     = `NS2CYC_UP(`INIT_PAUSE_NS),
   parameter int REFRESH_CYCLES  = LOW_POWER ? `NS2CYC_DN(`REFRESH_ROW_LP_NS)
                                             : `NS2CYC_DN(`REFRESH_ROW_STD_NS),
   parameter int PAGE_MAX_CYCLES = `NS2CYC_DN(`PAGE_ROW_ACTIVE_MAX_NS)
) (
   input  wire logic                 CORE_CLK,
   input  wire logic                 RST,
   input  wire logic                 REQ_VALID,
   output      logic                 REQ_READY,
   input  wire logic [1:0]           REQ_CMD,
   input  wire logic                 REQ_WRITE,
   input  wire logic                 REQ_HALF,
   input  wire logic [`ADDR_W-1:0]   REQ_ROW,
   input  wire logic [`ADDR_W-1:0]   REQ_COL,
   input  wire logic [`LANES-1:0]    REQ_BE,
   input  wire logic [`DATA_W-1:0]   REQ_WDATA,
   output      logic                 RSP_VALID,
   output      logic [`DATA_W-1:0]   RSP_RDATA,
   output      logic                 INIT_DONE,
   output      logic [`HALVES-1:0]   RAS_N,
   output      logic [`LANES-1:0]    CAS_N,
   output      logic                 WE_N,
   output      logic [`ADDR_W-1:0]   ADDR,
   output      logic [`DATA_W-1:0]   DQ_O,
   output      logic                 DQ_OE,
   input  wire logic [`DATA_W-1:0]   DQ_I
);
   localparam int CW    = 16;
   localparam int C_RP  = `NS2CYC_UP(`ROW_PRECHARGE_TIME_NS);
   localparam int C_RCD = `NS2CYC_UP(`ROW_TO_COL_DELAY_NS);
   localparam int C_COL = `NS2CYC_UP(`COL_ACTIVE_NS);
   localparam int C_CP  = `NS2CYC_UP(`COLUMN_PRECHARGE_TIME_NS);
   localparam int C_RAS = `NS2CYC_UP(`ROW_ACTIVE_MIN_NS);
   localparam int C_CSR = `NS2CYC_UP(`CBR_CAS_SETUP_NS);
   localparam int C_CPT = `NS2CYC_UP(`CBR_COUNTER_PRECHARGE_NS);
   localparam int C_PG  = C_CP + C_COL + 2;

   state_t              st_r, st_nxt;
   logic [CW-1:0]       cnt_r, cnt_nxt;
   logic [CW-1:0]       ref_cnt_r, ref_cnt_nxt;
   logic [CW-1:0]       page_cnt_r, page_cnt_nxt;
   logic                ref_pend_r, ref_pend_nxt;
   logic [3:0]          init_left_r, init_left_nxt;
   cmd_t                kind_r, kind_nxt;
   logic                wr_r, wr_nxt;
   logic                half_r, half_nxt;
   logic [`ADDR_W-1:0]  row_r, row_nxt;
   logic [`ADDR_W-1:0]  col_r, col_nxt;
   logic [`LANES-1:0]   be_r, be_nxt;
   logic [`DATA_W-1:0]  wdata_r, wdata_nxt;
   logic [`DATA_W-1:0]  rdata_r, rdata_nxt;
   logic                rsp_r, rsp_nxt;
   logic [`HALVES-1:0]  ras_n_r, ras_n_nxt;
   logic [`LANES-1:0]   cas_n_r, cas_n_nxt;
   logic                we_n_r, we_n_nxt;
   logic [`ADDR_W-1:0]  addr_r, addr_nxt;
   logic                dq_oe_r, dq_oe_nxt;

   wire cnt_done   = (cnt_r == '0);
   wire ref_tick   = (ref_cnt_r == '0);
   wire need_cbr   = ref_pend_r | (init_left_r != 4'h0);
   wire idle_take  = (st_r == ST_IDLE) && !need_cbr;
   wire page_hit   = (REQ_CMD == CMD_ACCESS) && (REQ_HALF == half_r) &&
                     (REQ_ROW == row_r) && (kind_r == CMD_ACCESS);
   // keep the burst under the page maximum
   wire page_room  = (32'(page_cnt_r) + 32'(C_PG)) < 32'(PAGE_MAX_CYCLES);
   wire page_take  = (st_r == ST_COL) && cnt_done && !ref_pend_r &&
                     page_hit && page_room;
   wire take       = REQ_VALID && (idle_take || page_take);
   wire cas_idle   = &cas_n_r;
   wire ras_idle   = &ras_n_r;

   assign REQ_READY = idle_take | page_take;
   assign INIT_DONE = (init_left_r == 4'h0) && (st_r != ST_INIT);
   assign RSP_VALID = rsp_r;
   assign RSP_RDATA = rdata_r;
   assign RAS_N     = ras_n_r;
   assign CAS_N     = cas_n_r;
   assign WE_N      = we_n_r;
   assign ADDR      = addr_r;
   assign DQ_O      = wdata_r;
   assign DQ_OE     = dq_oe_r;

   // distributed timer covers all rows within the period
   assign ref_cnt_nxt = ref_tick ? CW'(REFRESH_CYCLES - 1) : ref_cnt_r - 1'b1;
   // one row per interval; a tick wins over the clear
   assign ref_pend_nxt = ref_tick |
                         (ref_pend_r & !((st_r == ST_IDLE) && (init_left_r == 4'h0)));

   always_comb begin
      st_nxt        = st_r;
      cnt_nxt       = cnt_done ? cnt_r : cnt_r - 1'b1;
      page_cnt_nxt  = page_cnt_r + 1'b1;
      init_left_nxt = init_left_r;
      kind_nxt      = kind_r;
      wr_nxt        = wr_r;
      half_nxt      = half_r;
      row_nxt       = row_r;
      col_nxt       = col_r;
      be_nxt        = be_r;
      wdata_nxt     = wdata_r;
      rdata_nxt     = rdata_r;
      rsp_nxt       = 1'b0;
      case (st_r)
         ST_INIT: begin
            // power-up pause, then the init cycles
            if (cnt_done) begin
               st_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            // no hidden refresh; refresh after full precharge
            if (need_cbr) begin
               // column before row, internal counter row
               kind_nxt = CMD_CBR_REFRESH;
               st_nxt   = ST_CBR_CAS;
               cnt_nxt  = CW'(C_CSR - 1);
            end else if (REQ_VALID) begin
               kind_nxt  = cmd_t'(REQ_CMD == CMD_CBR_REFRESH ? CMD_ACCESS : REQ_CMD);
               wr_nxt    = REQ_WRITE;
               half_nxt  = REQ_HALF;
               row_nxt   = REQ_ROW;
               col_nxt   = REQ_COL;
               be_nxt    = REQ_BE;
               wdata_nxt = REQ_WDATA;
               page_cnt_nxt = '0;
               if (REQ_CMD == CMD_COUNTER_TEST) begin
                  // test sequences built by the user from these
                  // init cycles are done before any test is taken
                  st_nxt  = ST_CBR_CAS;
                  cnt_nxt = CW'(C_CSR - 1);
               end else if (REQ_CMD == CMD_ROW_REFRESH) begin
                  // row strobe only, held the active minimum
                  st_nxt  = ST_ROW;
                  cnt_nxt = CW'(C_RAS - 1);
               end else begin
                  st_nxt  = ST_ROW;
                  cnt_nxt = CW'(C_RCD - 1);
               end
            end
         end
         ST_ROW: begin
            if (cnt_done) begin
               if (kind_r == CMD_ROW_REFRESH) begin
                  st_nxt  = ST_PRE;
                  cnt_nxt = CW'(C_RP - 1);
               end else begin
                  st_nxt  = ST_COL;
                  cnt_nxt = CW'(C_COL - 1);
               end
            end
         end
         ST_COL: begin
            // strobes held the full column time
            if (cnt_done) begin
               rsp_nxt = 1'b1;
               // sample while the column strobe is still low
               if (!wr_r) begin
                  rdata_nxt = DQ_I;
               end
               if (take) begin
                  // next page cycle may be read or write
                  wr_nxt    = REQ_WRITE;
                  col_nxt   = REQ_COL;
                  be_nxt    = REQ_BE;
                  wdata_nxt = REQ_WDATA;
                  st_nxt    = ST_CPRE;
                  cnt_nxt   = CW'(C_CP - 1);
               end else begin
                  // both strobes rise on the same edge
                  st_nxt  = ST_PRE;
                  cnt_nxt = CW'(C_RP - 1);
               end
            end
         end
         ST_CPRE: begin
            // column precharge with the row held
            if (cnt_done) begin
               st_nxt  = ST_COL;
               cnt_nxt = CW'(C_COL - 1);
            end
         end
         ST_PRE: begin
            // precharge before the next active cycle
            if (cnt_done) begin
               st_nxt = ST_IDLE;
            end
         end
         ST_CBR_CAS: begin
            if (cnt_done) begin
               st_nxt  = ST_CBR_RAS;
               cnt_nxt = CW'(C_RAS - 1);
            end
         end
         ST_CBR_RAS: begin
            if (cnt_done) begin
               if (init_left_r != 4'h0) begin
                  init_left_nxt = init_left_r - 4'h1;
               end
               if (kind_r == CMD_COUNTER_TEST) begin
                  // row from the counter, column from ADDR
                  st_nxt  = ST_CT_CPRE;
                  cnt_nxt = CW'(C_CPT - 1);
               end else begin
                  st_nxt  = ST_PRE;
                  cnt_nxt = CW'(C_RP - 1);
               end
            end
         end
         ST_CT_CPRE: begin
            if (cnt_done) begin
               st_nxt  = ST_COL;
               cnt_nxt = CW'(C_COL - 1);
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // Pins are decoded from the next state so they leave flip-flops
   wire nxt_ras_low = (st_nxt == ST_ROW) || (st_nxt == ST_COL) ||
                      (st_nxt == ST_CPRE) || (st_nxt == ST_CBR_RAS) ||
                      (st_nxt == ST_CT_CPRE);
   wire nxt_cas_low = (st_nxt == ST_COL) || (st_nxt == ST_CBR_CAS) ||
                      (st_nxt == ST_CBR_RAS);
   wire nxt_cbr     = (st_nxt == ST_CBR_CAS) || (st_nxt == ST_CBR_RAS);
   wire nxt_wr_ph   = (st_nxt == ST_COL) || (st_nxt == ST_CPRE) ||
                      (st_nxt == ST_CT_CPRE) ||
                      ((st_nxt == ST_ROW) && (kind_nxt == CMD_ACCESS));
   // one row strobe per half; CBR refresh hits both halves, row-only refresh one half
   wire [`HALVES-1:0] half_sel = (kind_nxt == CMD_CBR_REFRESH) ? {`HALVES{1'b1}} :
                                 (half_nxt ? 2'h2 : 2'h1);
   assign ras_n_nxt = nxt_ras_low ? ~half_sel : {`HALVES{1'b1}};
   // byte lanes gated per column strobe
   assign cas_n_nxt = !nxt_cas_low ? {`LANES{1'b1}} :
                      nxt_cbr ? {`LANES{1'b0}} : ~be_nxt;
   // write line high through the refresh edges
   // early write: low from row fall, before column fall
   // reads keep it high from row fall
   assign we_n_nxt  = !(wr_nxt && nxt_wr_ph && !nxt_cbr);
   // row on row fall, column afterwards
   assign addr_nxt  = (st_nxt == ST_ROW) ? row_nxt : col_nxt;
   // data on the bus as the column strobe falls
   assign dq_oe_nxt = wr_nxt && (st_nxt == ST_COL);

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         st_r        <= ST_INIT;
         cnt_r       <= CW'(INIT_CYCLES - 1);
         ref_cnt_r   <= CW'(REFRESH_CYCLES - 1);
         page_cnt_r  <= '0;
         ref_pend_r  <= 1'b0;
         init_left_r <= 4'(`INIT_ROW_CYCLES);
         kind_r      <= CMD_ACCESS;
         wr_r        <= 1'b0;
         half_r      <= 1'b0;
         row_r       <= '0;
         col_r       <= '0;
         be_r        <= '0;
         wdata_r     <= '0;
         rdata_r     <= '0;
         rsp_r       <= 1'b0;
      end else begin
         st_r        <= st_nxt;
         cnt_r       <= cnt_nxt;
         ref_cnt_r   <= ref_cnt_nxt;
         page_cnt_r  <= page_cnt_nxt;
         ref_pend_r  <= ref_pend_nxt;
         init_left_r <= init_left_nxt;
         kind_r      <= kind_nxt;
         wr_r        <= wr_nxt;
         half_r      <= half_nxt;
         row_r       <= row_nxt;
         col_r       <= col_nxt;
         be_r        <= be_nxt;
         wdata_r     <= wdata_nxt;
         rdata_r     <= rdata_nxt;
         rsp_r       <= rsp_nxt;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ras_n_r <= {`HALVES{1'b1}};
         cas_n_r <= {`LANES{1'b1}};
         we_n_r  <= 1'b1;
         addr_r  <= '0;
         dq_oe_r <= 1'b0;
      end else begin
         ras_n_r <= ras_n_nxt;
         cas_n_r <= cas_n_nxt;
         we_n_r  <= we_n_nxt;
         addr_r  <= addr_nxt;
         dq_oe_r <= dq_oe_nxt;
      end
   end

   property p_precharge;
      @(posedge CORE_CLK) disable iff (RST)
      $rose(ras_idle) |-> ras_idle [*6];
   endproperty
   a_precharge: assert property (p_precharge) else $error("row precharge short");

   property p_read_capture;
      @(posedge CORE_CLK) disable iff (RST)
      rsp_r && !wr_r |-> !$past(cas_idle);
   endproperty
   a_read_capture: assert property (p_read_capture) else $error("read after column rise");

   property p_write_setup;
      @(posedge CORE_CLK) disable iff (RST)
      $fell(cas_idle) && !we_n_r |-> !$past(we_n_r);
   endproperty
   a_write_setup: assert property (p_write_setup) else $error("write line late");

   property p_write_data;
      @(posedge CORE_CLK) disable iff (RST)
      $fell(cas_idle) && !we_n_r |-> dq_oe_r && (DQ_O == wdata_r);
   endproperty
   a_write_data: assert property (p_write_data) else $error("write data missing");

   property p_write_hold;
      @(posedge CORE_CLK) disable iff (RST)
      $fell(cas_idle) && !we_n_r |-> (!cas_idle && !ras_idle) [*2];
   endproperty
   a_write_hold: assert property (p_write_hold) else $error("strobe hold after write");

   property p_ras_after_cas;
      @(posedge CORE_CLK) disable iff (RST)
      $rose(ras_idle) |-> cas_idle;
   endproperty
   a_ras_after_cas: assert property (p_ras_after_cas) else $error("row rose before column");

   property p_refresh_served;
      @(posedge CORE_CLK) disable iff (RST)
      $rose(ref_pend_r) && INIT_DONE |-> ##[1:1000] (st_r == ST_CBR_CAS);
   endproperty
   a_refresh_served: assert property (p_refresh_served) else $error("refresh not issued");

   property p_cbr_write_high;
      @(posedge CORE_CLK) disable iff (RST)
      (st_r == ST_CBR_RAS) && ($past(st_r) == ST_CBR_CAS) |-> we_n_r && $past(we_n_r);
   endproperty
   a_cbr_write_high: assert property (p_cbr_write_high) else $error("write line low in refresh");

   property p_init_quiet;
      @(posedge CORE_CLK) disable iff (RST)
      (st_r == ST_INIT) |-> ras_idle && cas_idle && !REQ_READY;
   endproperty
   a_init_quiet: assert property (p_init_quiet) else $error("activity during power-up pause");

   property p_read_setup;
      @(posedge CORE_CLK) disable iff (RST)
      $fell(cas_idle) && !ras_idle && !wr_r |-> we_n_r && $past(we_n_r);
   endproperty
   a_read_setup: assert property (p_read_setup) else $error("write line low on read");
endmodule : dram_host_ctrl

// >>> dram_host_consts.svh
// Timing and field constants for the page-mode DRAM host controller
`ifndef DRAM_HOST_CONSTS_SVH
`define DRAM_HOST_CONSTS_SVH
`define CLK_MHZ                     100
// Least times round up, longest times round down
`define NS2CYC_UP(ns)               ((((ns) * `CLK_MHZ) + 999) / 1000)
`define NS2CYC_DN(ns)               (((ns) * `CLK_MHZ) / 1000)
`define ROW_PRECHARGE_TIME_NS       60
`define ROW_TO_COL_DELAY_NS         20
`define COL_ACTIVE_NS               60
`define COLUMN_PRECHARGE_TIME_NS    10
`define COLUMN_HOLD_AFTER_WRITE_NS  20
`define ROW_HOLD_AFTER_WRITE_NS     20
`define ROW_ACTIVE_MIN_NS           60
`define CBR_CAS_SETUP_NS            5
`define WRITE_INACTIVE_LEAD_NS      10
`define WRITE_INACTIVE_HOLD_TIME_NS 10
`define CBR_COUNTER_PRECHARGE_NS    40
`define PAGE_ROW_ACTIVE_MAX_NS      10000
`define REFRESH_ROW_STD_NS          15600
`define REFRESH_ROW_LP_NS           124800
`define INIT_PAUSE_NS               200000
`define INIT_ROW_CYCLES             8
`define ROW_COUNT                   1024
`define ADDR_W                      10
`define DATA_W                      32
`define LANES                       4
`define HALVES                      2
`endif

// >>> dram_host_pkg.sv
// Types for the page-mode DRAM host controller
package dram_host_pkg;
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h0,
      ST_INIT    = 4'h1,
      ST_ROW     = 4'h2,
      ST_COL     = 4'h3,
      ST_CPRE    = 4'h4,
      ST_PRE     = 4'h5,
      ST_CBR_CAS = 4'h6,
      ST_CBR_RAS = 4'h7,
      ST_CT_CPRE = 4'h8
   } state_t;
   typedef enum logic [1:0] {
      CMD_ACCESS       = 2'h0,
      CMD_ROW_REFRESH  = 2'h1,
      CMD_COUNTER_TEST = 2'h2,
      CMD_CBR_REFRESH  = 2'h3
   } cmd_t;
endpackage : dram_host_pkg

// >>> dram_module_model.sv
// Behavioural page-mode DRAM module answering the host controller
`timescale 1ns/100ps
module dram_module_model #(
   parameter real ROW_PRECHARGE_NS = 60.0
) (
   input  wire logic [1:0]  ras_n,
   input  wire logic [3:0]  cas_n,
   input  wire logic        we_n,
   input  wire logic [9:0]  addr,
   input  wire logic [31:0] dq_o,
   input  wire logic        dq_oe,
   output      logic [31:0] dq,
   output      logic [15:0] viol,
   output      logic [15:0] cbr_cnt,
   output      logic [15:0] ref_cnt,
   output      logic [15:0] page_cnt,
   output      logic [9:0]  last_row
);
   logic [31:0] mem [int];
   logic [31:0] word;
   logic [9:0]  row_l [2];
   logic [9:0]  ctr;
   logic [1:0]  ras_q, cbr, paged;
   logic [3:0]  cas_q;
   logic        rd_open, fell, cbr_fell;
   int          ras_cyc, key;
   real         rise_t [2];

   initial begin
      {dq, viol, cbr_cnt, ref_cnt, page_cnt, last_row, ctr} = '0;
      ras_q = 2'h3;
      cas_q = 4'hf;
      {cbr, paged, rd_open, ras_cyc} = '0;
      rise_t = '{-1.0e3, -1.0e3};
   end

   // Strobes are registered, so a short settle sees every edge complete
   always @(ras_n, cas_n) begin
      #0.1;
      fell = 1'b0;
      cbr_fell = 1'b0;
      for (int h = 0; h < 2; h++) begin
         if (ras_q[h] && !ras_n[h]) begin
            if ($realtime - rise_t[h] < ROW_PRECHARGE_NS) viol++;
            fell = 1'b1;
            paged[h] = 1'b0;
            cbr[h] = ~&cas_q;
            if (cbr[h]) begin
               row_l[h] = ctr;
               cbr_fell = 1'b1;
               if (!we_n) viol++;
            end else begin
               row_l[h] = addr;
               if (ras_cyc < 8) viol++;
            end
            last_row = row_l[h];
         end
         if (!ras_q[h] && ras_n[h]) begin
            if (!cbr[h] && ~&cas_n) viol++;
            rise_t[h] = $realtime;
         end
      end
      if (fell) begin
         ras_cyc++;
         ref_cnt++;
      end
      if (cbr_fell) begin
         ctr++;
         cbr_cnt++;
      end
      if (|(cas_q & ~cas_n)) begin
         for (int h = 0; h < 2; h++) begin
            if (!ras_n[h]) begin
               if (paged[h]) page_cnt++;
               paged[h] = 1'b1;
               if (cbr[h] && cbr_cnt < 8) viol++;
               key = {h[0], row_l[h], addr};
               word = mem.exists(key) ? mem[key] : 32'h0;
               if (dq_oe) begin
                  if (we_n) viol++;
                  for (int i = 0; i < 4; i++) begin
                     if (!cas_n[i]) word[8*i +: 8] = dq_o[8*i +: 8];
                  end
                  mem[key] = word;
               end else begin
                  if (!we_n) viol++;
                  dq = word;
                  rd_open = 1'b1;
               end
            end
         end
      end
      // no pull-up: released bus shows inverted data
      if (~&cas_q && &cas_n && rd_open) begin
         dq = ~dq;
         rd_open = 1'b0;
      end
      ras_q = ras_n;
      cas_q = cas_n;
   end
endmodule : dram_module_model

// >>> dram_host_ctrl_tb_top.sv
// Self-checking bench for the DRAM host controller and module model
`timescale 1ns/100ps
module dram_host_ctrl_tb_top
   import dram_host_pkg::*;
;
   localparam int REF_CYC = 200;
   logic        CORE_CLK, RST, REQ_VALID, REQ_READY, REQ_WRITE, REQ_HALF;
   logic        RSP_VALID, INIT_DONE, WE_N, DQ_OE, ok;
   logic [1:0]  REQ_CMD, RAS_N;
   logic [3:0]  REQ_BE, CAS_N;
   logic [9:0]  REQ_ROW, REQ_COL, ADDR, last_row, ct_row;
   logic [31:0] REQ_WDATA, RSP_RDATA, DQ_O, DQ_I, d;
   logic [15:0] viol, cbr_cnt, ref_cnt, page_cnt, base;
   logic [31:0] rsp_q [$];
   int          fail_count, checked, cycles;

   dram_host_ctrl #(.INIT_CYCLES(50), .REFRESH_CYCLES(REF_CYC), .PAGE_MAX_CYCLES(60))
   dram_host_ctrl_i (.CORE_CLK(CORE_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
      .REQ_READY(REQ_READY), .REQ_CMD(REQ_CMD), .REQ_WRITE(REQ_WRITE),
      .REQ_HALF(REQ_HALF), .REQ_ROW(REQ_ROW), .REQ_COL(REQ_COL), .REQ_BE(REQ_BE),
      .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
      .INIT_DONE(INIT_DONE), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N),
      .ADDR(ADDR), .DQ_O(DQ_O), .DQ_OE(DQ_OE), .DQ_I(DQ_I));

   dram_module_model dram_module_model_i (.ras_n(RAS_N), .cas_n(CAS_N), .we_n(WE_N),
      .addr(ADDR), .dq_o(DQ_O), .dq_oe(DQ_OE), .dq(DQ_I), .viol(viol),
      .cbr_cnt(cbr_cnt), .ref_cnt(ref_cnt), .page_cnt(page_cnt), .last_row(last_row));

   initial CORE_CLK = 1'b0;
   always #5 CORE_CLK = ~CORE_CLK;

   always @(negedge CORE_CLK) begin
      if (RSP_VALID === 1'b1) rsp_q.push_back(RSP_RDATA);
   end

   // Whole run needs under two thousand cycles
   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      if (fail_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   // Request held from a falling edge until the edge that takes it
   task automatic send(input logic [1:0] cmd, input logic wr, input logic half,
                       input logic [9:0] row, input logic [9:0] col,
                       input logic [3:0] be, input logic [31:0] wd);
      @(negedge CORE_CLK);
      {REQ_VALID, REQ_CMD, REQ_WRITE, REQ_HALF} = {1'b1, cmd, wr, half};
      {REQ_ROW, REQ_COL, REQ_BE, REQ_WDATA} = {row, col, be, wd};
      #1;
      for (int n = 0; n < 2000 && REQ_READY !== 1'b1; n++) begin
         @(negedge CORE_CLK);
         #1;
      end
      @(posedge CORE_CLK);
   endtask : send

   task automatic idle(input int n);
      @(negedge CORE_CLK);
      REQ_VALID = 1'b0;
      repeat (n) @(negedge CORE_CLK);
   endtask : idle

   task automatic pop;
      for (int n = 0; n < 60 && rsp_q.size() == 0; n++) @(negedge CORE_CLK);
      ok = (rsp_q.size() != 0);
      d = ok ? rsp_q.pop_front() : 32'hx;
   endtask : pop

   task automatic chk_rd(input logic [31:0] exp);
      pop();
      cmp(d, exp);
   endtask : chk_rd

   task automatic chk_wr;
      pop();
      cmp({31'h0, ok}, 32'h1);
   endtask : chk_wr

   task automatic t_init;
      cmp({31'h0, REQ_READY}, 32'h0);
      for (int n = 0; n < 2000 && INIT_DONE !== 1'b1; n++) @(negedge CORE_CLK);
      cmp({31'h0, INIT_DONE}, 32'h1);
      cmp({31'h0, cbr_cnt >= 16'd8}, 32'h1);
   endtask : t_init

   task automatic t_lanes;
      rsp_q.delete();
      send(CMD_ACCESS, 1'b1, 1'b0, 10'h005, 10'h3ff, 4'hf, 32'ha5a5_0f0f);
      send(CMD_ACCESS, 1'b0, 1'b0, 10'h005, 10'h3ff, 4'hf, 32'h0);
      send(CMD_ACCESS, 1'b1, 1'b0, 10'h005, 10'h3ff, 4'h5, 32'h1122_3344);
      send(CMD_CBR_REFRESH, 1'b1, 1'b1, 10'h005, 10'h3ff, 4'hf, 32'hdead_beef);
      send(CMD_ACCESS, 1'b0, 1'b0, 10'h005, 10'h3ff, 4'hf, 32'h0);
      send(CMD_ACCESS, 1'b0, 1'b1, 10'h005, 10'h3ff, 4'hf, 32'h0);
      idle(2);
      chk_wr();
      chk_rd(32'ha5a5_0f0f);
      chk_wr();
      chk_wr();
      chk_rd(32'ha522_0f44);
      chk_rd(32'hdead_beef);
   endtask : t_lanes

   task automatic t_page;
      rsp_q.delete();
      base = page_cnt;
      send(CMD_ACCESS, 1'b1, 1'b1, 10'h009, 10'h000, 4'hf, 32'h0000_0001);
      send(CMD_ACCESS, 1'b1, 1'b1, 10'h009, 10'h3ff, 4'hf, 32'hffff_fffe);
      send(CMD_ACCESS, 1'b0, 1'b1, 10'h009, 10'h000, 4'hf, 32'h0);
      send(CMD_ACCESS, 1'b1, 1'b1, 10'h009, 10'h002, 4'hf, 32'h0000_0003);
      send(CMD_ACCESS, 1'b0, 1'b1, 10'h009, 10'h3ff, 4'hf, 32'h0);
      send(CMD_ACCESS, 1'b0, 1'b1, 10'h009, 10'h002, 4'hf, 32'h0);
      idle(2);
      chk_wr();
      chk_wr();
      chk_rd(32'h0000_0001);
      chk_wr();
      chk_rd(32'hffff_fffe);
      chk_rd(32'h0000_0003);
      cmp({31'h0, (page_cnt - base) >= 16'd3}, 32'h1);
   endtask : t_page

   task automatic t_refresh;
      rsp_q.delete();
      base = ref_cnt;
      idle(3 * REF_CYC);
      base = ref_cnt - base;
      cmp({31'h0, base >= 16'd2 && base <= 16'd4}, 32'h1);
      send(CMD_ACCESS, 1'b0, 1'b0, 10'h005, 10'h3ff, 4'hf, 32'h0);
      idle(1);
      chk_rd(32'ha522_0f44);
   endtask : t_refresh

   task automatic t_row_refresh;
      send(CMD_ROW_REFRESH, 1'b0, 1'b0, 10'h3ff, 10'h000, 4'hf, 32'h0);
      idle(2);
      cmp({22'h0, last_row}, 32'h0000_03ff);
      idle(20);
   endtask : t_row_refresh

   task automatic t_counter_test;
      rsp_q.delete();
      send(CMD_COUNTER_TEST, 1'b1, 1'b0, 10'h000, 10'h007, 4'hf, 32'h5a5a_c3c3);
      idle(1);
      chk_wr();
      ct_row = last_row;
      base = cbr_cnt;
      send(CMD_ACCESS, 1'b0, 1'b0, ct_row, 10'h007, 4'hf, 32'h0);
      idle(1);
      chk_rd(32'h5a5a_c3c3);
      send(CMD_COUNTER_TEST, 1'b0, 1'b0, 10'h000, 10'h007, 4'hf, 32'h0);
      idle(1);
      chk_rd(32'h0000_0000);
      cmp({22'h0, last_row}, {22'h0, ct_row + 10'(cbr_cnt - base)});
   endtask : t_counter_test

   initial begin
      {RST, REQ_VALID, REQ_CMD, REQ_WRITE, REQ_HALF} = {1'b1, 5'h0};
      {REQ_ROW, REQ_COL, REQ_BE, REQ_WDATA} = '0;
      {fail_count, checked, cycles} = '0;
      repeat (10) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
      RST = 1'b0;
      t_init();
      t_lanes();
      t_page();
      t_refresh();
      t_row_refresh();
      t_counter_test();
      cmp({16'h0, viol}, 32'h0);
      wrap_up();
   end
endmodule : dram_host_ctrl_tb_top
